// ### design/nvsrc_pkg.sv
// Shared constants and types for the nonvolatile SRAM store/recall host controller
package nvsrc_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int ACCESS_NS = 45;
  localparam int ACC_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int HS_PULSE_NS = 15;
  localparam int HS_CYC_RAW = (HS_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int HS_CYC = (HS_CYC_RAW < 2) ? 2 : HS_CYC_RAW;
  localparam int US_DIV = CLK_MHZ;
  localparam int STORE_GRACE_US = 70;
  localparam int SOFT_CMD_LATENCY_US = 70;
  localparam int NV_LOAD_US = 100;
  localparam int NV_SAVE_US = 12500;
  localparam int NV_SAVE_US_IND = 15000;

  // ----------------------------------------
  // Soft command address sequence
  // ----------------------------------------
  localparam int ADDR_W = 17;
  localparam int SEQ_LEN = 6;
  localparam logic [15:0] SEQ_A0 = 16'h4e38;
  localparam logic [15:0] SEQ_A1 = 16'hb1c7;
  localparam logic [15:0] SEQ_A2 = 16'h83e0;
  localparam logic [15:0] SEQ_A3 = 16'h7c1f;
  localparam logic [15:0] SEQ_A4 = 16'h703f;
  localparam logic [15:0] SEQ_STORE = 16'h8fc0;
  localparam logic [15:0] SEQ_RECALL = 16'h4c63;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_SOFT_STORE = 3'h2,
    OP_SOFT_RECALL = 3'h3,
    OP_HARD_STORE = 3'h4
  } nvsrc_op_type;

  typedef struct packed {
    nvsrc_op_type op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } nvsrc_cmd_type;

  typedef struct packed {
    logic [7:0] rdata;
    logic skipped;
  } nvsrc_rsp_type;

endpackage

// ### design/nvsrc_us_tick.sv
// Divider that gives a one-cycle enable pulse once per microsecond
`timescale 1ns/10ps
module nvsrc_us_tick #(
  parameter int DIV = 25
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  output logic tick_o
);
  logic [7:0] cnt;
  wire logic wrap = (cnt == 8'(DIV - 1));

  // Cleared at the start of each wait so the first tick is a full period away
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i || wrap) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= wrap && !clear_i;
    end
  end
endmodule

// ### design/nvsrc_host.sv
// Host-side controller that drives a byte-wide nonvolatile SRAM through its pins
`timescale 1ns/10ps

// What this block does
// - Address is held stable from the clock edge on which the strobes fall until they rise.
// - output_on_n stays high during every write cycle.
// - Soft commands issue six reads at the command addresses in order.
// - put_strobe_n stays high across all six sequence reads.
module nvsrc_host #(
  parameter int SAVE_US = nvsrc_pkg::NV_SAVE_US_IND
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CMD_VALID_I,
  input wire nvsrc_pkg::nvsrc_cmd_type CMD_I,
  output logic CMD_READY_O,
  output logic RSP_VALID_O,
  output nvsrc_pkg::nvsrc_rsp_type RSP_O,
  output logic DIRTY_O,
  output logic [nvsrc_pkg::ADDR_W-1:0] MEM_ADDR_O,
  input wire logic [7:0] MEM_DQ_I,
  output logic [7:0] MEM_DQ_O,
  output logic MEM_DQ_OE_O,
  output logic CHIP_ON_N_O,
  output logic OUTPUT_ON_N_O,
  output logic PUT_STROBE_N_O,
  input wire logic HSB_I,
  output logic HSB_O,
  output logic HSB_OE_O
);
  import nvsrc_pkg::*;

  // ----------------------------------------
  // State and datapath registers
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ACC = 5'h02,
    ST_RECOV = 5'h04,
    ST_HS_DRIVE = 5'h08,
    ST_NV_WAIT = 5'h10
  } nvsrc_state_type;

  nvsrc_state_type state, next_state;
  nvsrc_op_type op;
  logic [2:0] seq_idx;
  logic [2:0] cyc;
  logic [14:0] us_cnt;
  logic [14:0] min_us;
  logic seen_busy;
  logic seq_active;
  logic us_tick;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic accept = (state == ST_IDLE) && CMD_READY_O && CMD_VALID_I && HSB_I;
  wire logic is_write = (CMD_I.op == OP_WRITE);
  wire logic is_soft = (CMD_I.op == OP_SOFT_STORE) || (CMD_I.op == OP_SOFT_RECALL);
  wire logic is_hard = (CMD_I.op == OP_HARD_STORE);
  wire logic acc_last = (state == ST_ACC) && (cyc == 3'(ACC_CYC - 1));
  wire logic hs_last = (state == ST_HS_DRIVE) && (cyc == 3'(HS_CYC - 1));
  wire logic seq_last = (seq_idx == 3'(SEQ_LEN - 1));
  wire logic min_done = (us_cnt >= min_us);
  wire logic save_timeout = (us_cnt >= 15'(32'(min_us) + SAVE_US));
  wire logic nv_done = (state == ST_NV_WAIT) && min_done && (HSB_I || save_timeout);
  wire logic foreign_busy = (state == ST_IDLE) && !HSB_I;
  // Address of the read that follows the current sequence step
  wire logic [15:0] seq_addr =
    (seq_idx == 3'd0) ? SEQ_A1 :
    (seq_idx == 3'd1) ? SEQ_A2 :
    (seq_idx == 3'd2) ? SEQ_A3 :
    (seq_idx == 3'd3) ? SEQ_A4 :
    (op == OP_SOFT_RECALL) ? SEQ_RECALL : SEQ_STORE;
  wire logic [14:0] nv_min_us =
    (op == OP_SOFT_RECALL) ? 15'(SOFT_CMD_LATENCY_US + NV_LOAD_US) :
    (op == OP_SOFT_STORE) ? 15'(SOFT_CMD_LATENCY_US) : 15'(STORE_GRACE_US);

  nvsrc_us_tick #(
    .DIV(US_DIV)
  ) u_tick (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .clear_i(state != ST_NV_WAIT),
    .tick_o(us_tick)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (foreign_busy) begin
          next_state = ST_NV_WAIT;
        end else if (accept && is_hard) begin
          next_state = ST_HS_DRIVE;
        end else if (accept) begin
          next_state = ST_ACC;
        end
      end
      ST_ACC: next_state = acc_last ? ST_RECOV : ST_ACC;
      ST_RECOV: next_state = !seq_active ? ST_IDLE : (seq_last ? ST_NV_WAIT : ST_ACC);
      ST_HS_DRIVE: next_state = hs_last ? ST_NV_WAIT : ST_HS_DRIVE;
      ST_NV_WAIT: next_state = nv_done ? ST_IDLE : ST_NV_WAIT;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Sequencing counters
  // ----------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I || state != next_state) begin
      cyc <= 3'h0;
    end else begin
      cyc <= cyc + 3'h1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      op <= OP_READ;
      seq_active <= 1'b0;
      seq_idx <= 3'h0;
    end else if (accept || foreign_busy) begin
      // A wait for a store started elsewhere must not answer for the last command
      op <= accept ? CMD_I.op : OP_READ;
      seq_active <= accept && is_soft;
      seq_idx <= 3'h0;
    end else if (state == ST_RECOV && seq_active) begin
      seq_idx <= seq_idx + 3'h1;
      seq_active <= !seq_last;
    end
  end

  // The us counter restarts on entry; the device busy is sampled as a level
  always_ff @(posedge CLK_I) begin
    if (RST_I || state != ST_NV_WAIT) begin
      us_cnt <= 15'h0000;
      seen_busy <= 1'b0;
    end else begin
      if (us_tick) begin
        us_cnt <= us_cnt + 15'h0001;
      end
      if (!HSB_I && !HSB_OE_O) begin
        seen_busy <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I || foreign_busy) begin
      min_us <= 15'h0000;
    end else if (state != ST_NV_WAIT && next_state == ST_NV_WAIT) begin
      min_us <= nv_min_us;
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Address and data change only while all strobes are high, so the device
  // never sees an address move inside a write
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      MEM_ADDR_O <= '0;
      MEM_DQ_O <= 8'h00;
    end else if (accept) begin
      MEM_ADDR_O <= is_soft ? {1'b0, SEQ_A0} : CMD_I.addr;
      MEM_DQ_O <= CMD_I.wdata;
    end else if (state == ST_RECOV && seq_active && !seq_last) begin
      MEM_ADDR_O <= {1'b0, seq_addr};
    end
  end

  wire logic go_acc = (next_state == ST_ACC);
  wire logic go_write = go_acc && (accept ? is_write : op == OP_WRITE) && !(accept ? is_soft : seq_active);

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      CHIP_ON_N_O <= 1'b1;
      OUTPUT_ON_N_O <= 1'b1;
      PUT_STROBE_N_O <= 1'b1;
      MEM_DQ_OE_O <= 1'b0;
      HSB_OE_O <= 1'b0;
      HSB_O <= 1'b0;
    end else begin
      CHIP_ON_N_O <= !go_acc;
      OUTPUT_ON_N_O <= !(go_acc && !go_write);
      PUT_STROBE_N_O <= !go_write;
      // Data stays driven through recovery so it holds past the strobe release
      MEM_DQ_OE_O <= go_write || (state == ST_ACC && op == OP_WRITE);
      HSB_OE_O <= (next_state == ST_HS_DRIVE);
      HSB_O <= 1'b0;
    end
  end

  // ----------------------------------------
  // User side
  // ----------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      RSP_VALID_O <= 1'b0;
      RSP_O <= '0;
      DIRTY_O <= 1'b0;
      CMD_READY_O <= 1'b0;
    end else begin
      CMD_READY_O <= (next_state == ST_IDLE) && HSB_I;
      RSP_VALID_O <= 1'b0;
      if (acc_last && !seq_active && op == OP_READ) begin
        RSP_O.rdata <= MEM_DQ_I;
      end
      if (state == ST_RECOV && (op == OP_READ || op == OP_WRITE)) begin
        RSP_VALID_O <= 1'b1;
        RSP_O.skipped <= 1'b0;
      end else if (nv_done && op != OP_READ && op != OP_WRITE) begin
        RSP_VALID_O <= 1'b1;
        RSP_O.skipped <= (op == OP_HARD_STORE) && !seen_busy;
      end
      // A write in the same cycle as a completed store keeps the flag set
      if (state == ST_ACC && op == OP_WRITE) begin
        DIRTY_O <= 1'b1;
      end else if (nv_done && (op != OP_HARD_STORE || seen_busy)) begin
        DIRTY_O <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_read_open;
    !OUTPUT_ON_N_O && !CHIP_ON_N_O;
  endsequence
  sequence s_read_close;
    OUTPUT_ON_N_O && CHIP_ON_N_O;
  endsequence

  AST_READ_SHAPE: assert property ($fell(OUTPUT_ON_N_O) |-> s_read_open [*2] ##1 s_read_close)
    else $error("read strobes not held for two cycles");
  AST_WRITE_OE_HIGH: assert property (!PUT_STROBE_N_O |-> OUTPUT_ON_N_O && !CHIP_ON_N_O && MEM_DQ_OE_O)
    else $error("output enable low during write");
  AST_ADDR_STABLE: assert property (!PUT_STROBE_N_O && $past(!PUT_STROBE_N_O) |-> $stable(MEM_ADDR_O))
    else $error("address moved inside write");
  AST_WRITE_NOT_BUSY: assert property ($fell(PUT_STROBE_N_O) |-> $past(HSB_I))
    else $error("write started while busy pin low");
  AST_SEQ_NO_WRITE: assert property (seq_active |-> PUT_STROBE_N_O)
    else $error("write strobe low in command sequence");
  AST_SEQ_FIRST: assert property (seq_active && seq_idx == 3'd0 && !CHIP_ON_N_O |-> MEM_ADDR_O == {1'b0, SEQ_A0})
    else $error("command sequence does not open at first address");
  AST_SEQ_MSB: assert property (seq_active && !CHIP_ON_N_O |-> !MEM_ADDR_O[16])
    else $error("top address bit set in command sequence");
  AST_NV_QUIET: assert property (state == ST_NV_WAIT |-> CHIP_ON_N_O && PUT_STROBE_N_O)
    else $error("memory access during store or recall");
  AST_HS_PULSE: assert property ($rose(HSB_OE_O) |-> HSB_OE_O [*2] ##1 !HSB_OE_O)
    else $error("hard store request pulse wrong length");
  AST_DIRTY_SET: assert property ($fell(PUT_STROBE_N_O) |-> ##1 DIRTY_O)
    else $error("dirty flag not set by write");
endmodule

// ### verification/nvsrc_dev_model.sv
// Behavioural model of the byte-wide nonvolatile SRAM driven by the host controller
`timescale 1ns/10ps
module nvsrc_dev_model #(
  parameter int STORE_NS = 10000,
  parameter int RECALL_NS = 50000
) (
  input wire logic [16:0] addr_i,
  input wire logic [7:0] dq_i,
  input wire logic chip_on_n_i,
  input wire logic output_on_n_i,
  input wire logic put_strobe_n_i,
  input wire logic save_busy_n_i,
  input wire logic slow_i,
  input wire logic power_fail_i,
  output logic [7:0] dq_o,
  output logic busy_pull_o,
  output int store_cnt_o
);
  logic [7:0] mem [0:131071];
  logic [7:0] nv [0:131071];
  logic [15:0] seq [0:4];
  logic [7:0] last;
  logic dirty = 0;
  logic busy = 0;
  logic wr_ok = 0;
  int step = 0;
  wire rd_act = !chip_on_n_i && !output_on_n_i && put_strobe_n_i && save_busy_n_i && !busy;
  wire wr_act = !chip_on_n_i && !put_strobe_n_i;
  wire sixth = step == 5 && (addr_i[15:0] == 16'h8fc0 || addr_i[15:0] == 16'h4c63);
  // Released bus shows the inverse of the last value, so stale data cannot pass
  assign dq_o = (rd_act && !sixth) ? mem[addr_i] : ~last;

  initial begin
    seq = '{16'h4e38, 16'hb1c7, 16'h83e0, 16'h7c1f, 16'h703f};
    for (int i = 0; i < 131072; i++) begin
      mem[i] = i[7:0] ^ 8'h5a;
    end
    nv = mem;
    last = 8'h00;
    busy_pull_o = 0;
    store_cnt_o = 0;
  end

  // ----
  // Nonvolatile cycles
  // ----
  task automatic do_store();
    busy = 1;
    busy_pull_o = 1;
    #(STORE_NS);
    nv = mem;
    store_cnt_o++;
    dirty = 0;
    busy = 0;
    busy_pull_o = 0;
  endtask

  task automatic do_recall();
    busy = 1;
    #(RECALL_NS);
    mem = nv;
    dirty = 0;
    busy = 0;
  endtask

  // Grace before a pin store; slow mode leaves the host little margin
  task automatic hard_req();
    #(slow_i ? 60000 : 2000);
    if (dirty && !busy) begin
      do_store();
    end
  endtask

  always @(negedge rd_act) begin
    last = mem[addr_i];
    if (step == 5) begin
      if (addr_i[15:0] == 16'h8fc0) fork do_store(); join_none
      else if (addr_i[15:0] == 16'h4c63) fork do_recall(); join_none
      step = 0;
    end else if (addr_i[15:0] == seq[step]) begin
      step++;
    end else begin
      step = (addr_i[15:0] == seq[0]) ? 1 : 0;
    end
  end

  // Write qualified at its opening edge, so a held write after busy stays inhibited
  always @(posedge wr_act) begin
    wr_ok = (wr_act === 1'b1) && save_busy_n_i && !busy;
    step = 0;
  end

  always @(negedge wr_act) begin
    if (wr_ok === 1'b1 && !busy) begin
      mem[addr_i] = dq_i;
      dirty = 1;
    end
    wr_ok = 0;
  end

  always @(negedge save_busy_n_i) begin
    if (!busy) fork hard_req(); join_none
  end

  // Supply loss: backup node isolated, store runs only if dirty
  always @(posedge power_fail_i) begin
    if (dirty && !busy) fork do_store(); join_none
  end
endmodule

// ### verification/nvsrc_host_tb.sv
// Self-checking testbench for the nonvolatile SRAM host controller
`timescale 1ns/10ps
module nvsrc_host_tb;
  import nvsrc_pkg::*;
  logic clk_i, rst_i, cmd_valid, cmd_ready, rsp_valid, dirty, dq_oe, ce_n, oe_n, we_n, save_oe, dev_pull;
  logic slow, power_fail, in_soft, prev_strobe, hsb_val;
  nvsrc_cmd_type cmd;
  nvsrc_rsp_type rsp;
  logic [ADDR_W-1:0] mem_addr, prev_addr;
  logic [7:0] dq_host, dq_dev;
  int store_cnt, lat, base, bad_count, comparisons;
  wire [7:0] dq_bus = dq_oe ? dq_host : dq_dev;
  // Pulled-up store/busy wire, low while either side pulls it
  wire save_busy_wire = !((save_oe && !hsb_val) | dev_pull);

  nvsrc_host #(.SAVE_US(20)) uut (
    .CLK_I(clk_i), .RST_I(rst_i), .CMD_VALID_I(cmd_valid), .CMD_I(cmd), .CMD_READY_O(cmd_ready),
    .RSP_VALID_O(rsp_valid), .RSP_O(rsp), .DIRTY_O(dirty), .MEM_ADDR_O(mem_addr), .MEM_DQ_I(dq_bus),
    .MEM_DQ_O(dq_host), .MEM_DQ_OE_O(dq_oe), .CHIP_ON_N_O(ce_n), .OUTPUT_ON_N_O(oe_n),
    .PUT_STROBE_N_O(we_n), .HSB_I(save_busy_wire), .HSB_O(hsb_val), .HSB_OE_O(save_oe)
  );

  nvsrc_dev_model dev (
    .addr_i(mem_addr), .dq_i(dq_bus), .chip_on_n_i(ce_n), .output_on_n_i(oe_n), .put_strobe_n_i(we_n),
    .save_busy_n_i(save_busy_wire), .slow_i(slow), .power_fail_i(power_fail), .dq_o(dq_dev),
    .busy_pull_o(dev_pull), .store_cnt_o(store_cnt)
  );

  // ----
  // Shared tasks
  // ----
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic do_cmd(input nvsrc_op_type op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cmd = '{op, a, d};
    cmd_valid = 1;
    while (!(cmd_ready === 1'b1 && save_busy_wire === 1'b1) && n < 20000) begin
      @(posedge clk_i);
      #2;
      n++;
    end
    @(posedge clk_i);
    #2;
    cmd_valid = 0;
    lat = 0;
    while (rsp_valid !== 1'b1 && lat < 20000) begin
      @(posedge clk_i);
      #2;
      lat++;
    end
    check("response", 1, rsp_valid);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_rw();
    do_cmd(OP_WRITE, 17'h10005, 8'ha5);
    // Edges after the take: strobe width plus one recovery cycle
    check("write latency", ACC_CYC + 1, lat);
    check("dirty after write", 1, dirty);
    do_cmd(OP_WRITE, 17'h00005, 8'h3c);
    do_cmd(OP_READ, 17'h10005, 8'h00);
    check("read latency", ACC_CYC + 1, lat);
    check("read data upper", 8'ha5, rsp.rdata);
    do_cmd(OP_READ, 17'h00005, 8'h00);
    check("read data lower", 8'h3c, rsp.rdata);
  endtask

  task automatic t_soft();
    base = store_cnt;
    in_soft = 1;
    do_cmd(OP_SOFT_STORE, 17'h00000, 8'h00);
    check("soft store count", base + 1, store_cnt);
    check("dirty after store", 0, dirty);
    do_cmd(OP_SOFT_STORE, 17'h00000, 8'h00);
    in_soft = 0;
    check("clean soft store count", base + 2, store_cnt);
  endtask

  task automatic t_recall();
    do_cmd(OP_WRITE, 17'h00005, 8'h77);
    in_soft = 1;
    do_cmd(OP_SOFT_RECALL, 17'h00000, 8'h00);
    in_soft = 0;
    check("dirty after recall", 0, dirty);
    do_cmd(OP_READ, 17'h00005, 8'h00);
    check("recalled data", 8'h3c, rsp.rdata);
  endtask

  task automatic t_hard();
    base = store_cnt;
    do_cmd(OP_HARD_STORE, 17'h00000, 8'h00);
    check("clean hard skipped", 1, rsp.skipped);
    check("clean hard count", base, store_cnt);
    do_cmd(OP_WRITE, 17'h00042, 8'h5e);
    slow = 1;
    do_cmd(OP_HARD_STORE, 17'h00000, 8'h00);
    slow = 0;
    check("dirty hard skipped", 0, rsp.skipped);
    check("dirty hard count", base + 1, store_cnt);
    check("dirty after hard store", 0, dirty);
  endtask

  task automatic t_power();
    do_cmd(OP_WRITE, 17'h00123, 8'h11);
    base = store_cnt;
    power_fail = 1;
    repeat (3) @(posedge clk_i);
    #2;
    check("ready in power store", 0, cmd_ready);
    do_cmd(OP_READ, 17'h00123, 8'h00);
    power_fail = 0;
    check("power store count", base + 1, store_cnt);
    check("dirty after power store", 0, dirty);
    check("read after power store", 8'h11, rsp.rdata);
  endtask

  // Pin monitor: write cycles, held address and busy lockout
  always @(posedge clk_i) begin
    if (rst_i === 1'b0) begin
      if (we_n === 1'b0) check("output enable in write", 1, oe_n);
      if (we_n === 1'b0) check("busy wire in write", 1, save_busy_wire);
      if (in_soft) check("write strobe in sequence", 1, we_n);
      if (prev_strobe && ce_n === 1'b0) check("address under strobe", prev_addr, mem_addr);
      if (dev.busy) check("select while busy", 1, ce_n);
    end
    prev_strobe <= (ce_n === 1'b0);
    prev_addr <= mem_addr;
  end

  initial begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    #2000000;
    bad_count++;
    $display("CHECK FAILED watchdog expected %s seen %s", "done", "hang");
    print_verdict();
  end

  initial begin
    rst_i = 1;
    cmd_valid = 0;
    cmd = '0;
    slow = 0;
    power_fail = 0;
    in_soft = 0;
    bad_count = 0;
    comparisons = 0;
    repeat (6) @(posedge clk_i);
    #2;
    rst_i = 0;
    check("dirty after reset", 0, dirty);
    check("select after reset", 1, ce_n);
    t_rw();
    t_soft();
    t_recall();
    t_hard();
    t_power();
    print_verdict();
  end
endmodule
